// *** common/pcw_defs.vh ***
// offsets, field positions, reset values and timing counts of the socket window bank
`ifndef PCW_DEFS_VH
`define PCW_DEFS_VH

// register offsets in the socket register space
`define PCW_OFF_IO_CTL 8'h07
`define PCW_OFF_IO0_START_LO 8'h08
`define PCW_OFF_IO0_START_HI 8'h09
`define PCW_OFF_IO0_END_LO 8'h0a
`define PCW_OFF_IO0_END_HI 8'h0b
`define PCW_OFF_IO1_START_LO 8'h0c
`define PCW_OFF_IO1_START_HI 8'h0d
`define PCW_OFF_IO1_END_LO 8'h0e
`define PCW_OFF_IO1_END_HI 8'h0f
`define PCW_OFF_MEM0_START_LO 8'h10
`define PCW_OFF_MEM1_START_LO 8'h18
`define PCW_OFF_MEM2_START_LO 8'h20
`define PCW_OFF_MEM3_START_LO 8'h28
`define PCW_OFF_MEM4_START_LO 8'h30

// io window stride between window 0 and window 1 address registers
`define PCW_IO_STRIDE 8'h04
// memory window stride
`define PCW_MEM_STRIDE 8'h08

// every register of the bank resets to this value
`define PCW_RESET_VAL 8'h00

// io window timing control fields, window n uses bit (4*n + pos)
`define PCW_BIT_FIXED_WIDTH 0
`define PCW_BIT_AUTO_SIZE 1
`define PCW_BIT_SHORT_WAIT 2
`define PCW_BIT_LONG_WAIT 3
`define PCW_CTL_FIELD_W 4

// memory window start low byte maps onto host address bits a19..a12
`define PCW_MEM_ADDR_MSB 19
`define PCW_MEM_ADDR_LSB 12

// isa-equivalent cycle timing, in isa clocks
`define PCW_ISA_DIV 8'h03
`define PCW_STD8_ISA 4'h6
`define PCW_SHORT8_ISA 4'h3
`define PCW_STD16_ISA 4'h3
`define PCW_LONG_EXTRA_ISA 4'h1

`endif

// *** design/pcw_io_window.v ***
// address match, transfer width and cycle-length selection of one io window
`timescale 1ns/1ps
`include "pcw_defs.vh"
module pcw_io_window (
   input wire [15:0] start_addr_in,
   input wire [15:0] end_addr_in,
   input wire window_on_in,
   input wire [3:0] ctl_in,
   input wire iois16_in,
   input wire [15:0] host_addr_in,
   output wire hit_out,
   output wire wide_out,
   output wire long_out,
   output wire short_out
);
   wire auto_size;
   wire fixed_width;

   assign auto_size = ctl_in[`PCW_BIT_AUTO_SIZE];
   assign fixed_width = ctl_in[`PCW_BIT_FIXED_WIDTH];

   // a disabled window never claims, whatever its limits say
   // both limits are inclusive
   assign hit_out = window_on_in && (host_addr_in >= start_addr_in) &&
                    (host_addr_in <= end_addr_in);

   // fixed width is ignored while auto-size is set
   assign wide_out = auto_size ? iois16_in : fixed_width;

   // long wait only touches 16-bit cycles, short wait only 8-bit cycles
   assign long_out = wide_out && ctl_in[`PCW_BIT_LONG_WAIT];
   assign short_out = !wide_out && ctl_in[`PCW_BIT_SHORT_WAIT];
endmodule

// *** design/pcw_cycle_timer.v ***
// times one io cycle in isa-equivalent clocks derived from the bus clock
`timescale 1ns/1ps
`include "pcw_defs.vh"
module pcw_cycle_timer #(
   parameter [7:0] ISA_DIV = `PCW_ISA_DIV,
   parameter [3:0] STD8_ISA = `PCW_STD8_ISA,
   parameter [3:0] SHORT8_ISA = `PCW_SHORT8_ISA,
   parameter [3:0] STD16_ISA = `PCW_STD16_ISA
) (
   input wire clk,
   input wire rst_n,
   input wire start_in,
   input wire wide_in,
   input wire long_in,
   input wire short_in,
   output wire busy_out,
   output reg done_out
);
   localparam [1:0] ST_IDLE = 2'b01;
   localparam [1:0] ST_RUN = 2'b10;

   reg [1:0] state_ff;
   reg [1:0] nxt_state;
   reg [7:0] div_ff;
   reg [3:0] cnt_ff;
   reg [3:0] len_ff;
   wire isa_tick;
   reg [3:0] len_sel;

   // divider restarts with each cycle so the first isa clock has full length
   assign isa_tick = (div_ff == ISA_DIV - 8'h01);
   assign busy_out = state_ff[1];

   always @* begin
      if (wide_in) begin
         len_sel = long_in ? STD16_ISA + `PCW_LONG_EXTRA_ISA : STD16_ISA;
      end else begin
         len_sel = short_in ? SHORT8_ISA : STD8_ISA;
      end
   end

   always @* begin
      case (state_ff)
         ST_IDLE: nxt_state = start_in ? ST_RUN : ST_IDLE;
         ST_RUN: nxt_state = (isa_tick && cnt_ff == len_ff - 4'h1) ? ST_IDLE : ST_RUN;
         default: nxt_state = ST_IDLE;
      endcase
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_ff <= ST_IDLE;
         div_ff <= 8'h00;
         cnt_ff <= 4'h0;
         len_ff <= 4'h0;
         done_out <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         done_out <= state_ff[1] && nxt_state[0];
         if (state_ff[0]) begin
            div_ff <= 8'h00;
            cnt_ff <= 4'h0;
            if (start_in) begin
               len_ff <= len_sel;
            end
         end else if (isa_tick) begin
            div_ff <= 8'h00;
            cnt_ff <= cnt_ff + 4'h1;
         end else begin
            div_ff <= div_ff + 8'h01;
         end
      end
   end
endmodule

// *** design/pcw_top.v ***
// socket window configuration bank: io window timing, io limits, memory window start bytes
// Overview of operation
// - a window's long-wait bit adds one isa wait state to its 16-bit io cycles only.
// - a window's short-wait bit cuts its 8-bit io cycles to three isa clocks only.
// - with auto-size set the transfer width follows the card's iois16 signal.
// - the fixed width bit picks 8 bits at 0 and 16 bits at 1, ignored under auto-size.
// - the start low byte register forms bits 7..0 of the io window start address.
// - the start high byte register forms bits 15..8 of the io window start address.
// - the end low byte register forms bits 7..0 of the io window end address.
// - the end high byte register forms bits 15..8 of the io window end address.
// - each memory window start low byte stands for host address bits a19..a12.
// - a window whose enable bit is 0 never claims a host cycle.
`timescale 1ns/1ps
`include "pcw_defs.vh"
module pcw_top #(
   parameter IO_WINDOWS = 2,
   parameter MEM_WINDOWS = 5,
   parameter [7:0] ISA_DIV = `PCW_ISA_DIV
) (
   input wire CLK_IN,
   input wire RST_N_IN,
   input wire [7:0] REG_ADDR_IN,
   input wire [7:0] REG_WDATA_IN,
   input wire REG_WR_IN,
   input wire REG_RD_IN,
   output reg [7:0] REG_RDATA_OUT,
   output reg REG_RVALID_OUT,
   input wire [1:0] IO_WINDOW_ON_IN,
   input wire [4:0] MEM_WINDOW_ON_IN,
   input wire CARD_IOIS16_N_IN,
   input wire HOST_IO_REQ_IN,
   input wire [15:0] HOST_IO_ADDR_IN,
   input wire HOST_MEM_REQ_IN,
   input wire [23:0] HOST_MEM_ADDR_IN,
   input wire [4:0] MEM_LIMIT_OK_IN,
   output reg IO_CLAIM_OUT,
   output reg IO_WINDOW_SEL_OUT,
   output reg IO_WIDE_OUT,
   output wire IO_BUSY_OUT,
   output wire IO_DONE_OUT,
   output reg [4:0] MEM_CLAIM_OUT,
   output reg [39:0] MEM_START_OUT
);
   reg [7:0] io_ctl_ff;
   // io limit bytes: index 4*w + {start lo, start hi, end lo, end hi}
   reg [7:0] io_lim_ff [0:7];
   reg [7:0] mem_start_ff [0:4];
   reg iois16_meta_ff;
   reg iois16_sync_ff;
   reg [7:0] rd_mux;
   wire [1:0] win_hit;
   wire [1:0] win_wide;
   wire [1:0] win_long;
   wire [1:0] win_short;
   wire [4:0] mem_hit;
   wire sel;
   wire any_hit;
   wire take_io;
   integer i;

   // the card pin is asynchronous to the bus clock
   always @(posedge CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         iois16_meta_ff <= 1'b0;
         iois16_sync_ff <= 1'b0;
      end else begin
         iois16_meta_ff <= !CARD_IOIS16_N_IN;
         iois16_sync_ff <= iois16_meta_ff;
      end
   end

   // register writes; all bytes fully read/write
   always @(posedge CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         io_ctl_ff <= `PCW_RESET_VAL;
         for (i = 0; i < 8; i = i + 1) begin
            io_lim_ff[i] <= `PCW_RESET_VAL;
         end
         for (i = 0; i < 5; i = i + 1) begin
            mem_start_ff[i] <= `PCW_RESET_VAL;
         end
      end else if (REG_WR_IN) begin
         if (REG_ADDR_IN == `PCW_OFF_IO_CTL) begin
            io_ctl_ff <= REG_WDATA_IN;
         end
         if (REG_ADDR_IN >= `PCW_OFF_IO0_START_LO && REG_ADDR_IN <= `PCW_OFF_IO1_END_HI) begin
            io_lim_ff[REG_ADDR_IN[2:0]] <= REG_WDATA_IN;
         end
         case (REG_ADDR_IN)
            `PCW_OFF_MEM0_START_LO: mem_start_ff[0] <= REG_WDATA_IN;
            `PCW_OFF_MEM1_START_LO: mem_start_ff[1] <= REG_WDATA_IN;
            `PCW_OFF_MEM2_START_LO: mem_start_ff[2] <= REG_WDATA_IN;
            `PCW_OFF_MEM3_START_LO: mem_start_ff[3] <= REG_WDATA_IN;
            `PCW_OFF_MEM4_START_LO: mem_start_ff[4] <= REG_WDATA_IN;
            default: ;
         endcase
      end
   end

   // unmapped offsets read as zero
   always @* begin
      rd_mux = 8'h00;
      if (REG_ADDR_IN == `PCW_OFF_IO_CTL) begin
         rd_mux = io_ctl_ff;
      end else if (REG_ADDR_IN >= `PCW_OFF_IO0_START_LO &&
                   REG_ADDR_IN <= `PCW_OFF_IO1_END_HI) begin
         rd_mux = io_lim_ff[REG_ADDR_IN[2:0]];
      end else begin
         case (REG_ADDR_IN)
            `PCW_OFF_MEM0_START_LO: rd_mux = mem_start_ff[0];
            `PCW_OFF_MEM1_START_LO: rd_mux = mem_start_ff[1];
            `PCW_OFF_MEM2_START_LO: rd_mux = mem_start_ff[2];
            `PCW_OFF_MEM3_START_LO: rd_mux = mem_start_ff[3];
            `PCW_OFF_MEM4_START_LO: rd_mux = mem_start_ff[4];
            default: rd_mux = 8'h00;
         endcase
      end
   end

   always @(posedge CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         REG_RDATA_OUT <= 8'h00;
         REG_RVALID_OUT <= 1'b0;
      end else begin
         REG_RVALID_OUT <= REG_RD_IN;
         if (REG_RD_IN) begin
            REG_RDATA_OUT <= rd_mux;
         end
      end
   end

   genvar w;
   generate
      for (w = 0; w < IO_WINDOWS; w = w + 1) begin : g_io
         pcw_io_window u_win (
            .start_addr_in({io_lim_ff[4*w+1], io_lim_ff[4*w]}),
            .end_addr_in({io_lim_ff[4*w+3], io_lim_ff[4*w+2]}),
            .window_on_in(IO_WINDOW_ON_IN[w]),
            .ctl_in(io_ctl_ff[`PCW_CTL_FIELD_W*w +: `PCW_CTL_FIELD_W]),
            .iois16_in(iois16_sync_ff),
            .host_addr_in(HOST_IO_ADDR_IN),
            .hit_out(win_hit[w]),
            .wide_out(win_wide[w]),
            .long_out(win_long[w]),
            .short_out(win_short[w])
         );
      end
      for (w = 0; w < MEM_WINDOWS; w = w + 1) begin : g_mem
         // start byte compares against a19..a12; higher bits and end limit come in
         assign mem_hit[w] = MEM_WINDOW_ON_IN[w] && MEM_LIMIT_OK_IN[w] &&
            (HOST_MEM_ADDR_IN[`PCW_MEM_ADDR_MSB:`PCW_MEM_ADDR_LSB] >= mem_start_ff[w]);
      end
   endgenerate

   // window 0 wins when both windows overlap
   assign sel = !win_hit[0];
   assign any_hit = |win_hit;
   // requests that arrive while a cycle is timed are not claimed
   assign take_io = HOST_IO_REQ_IN && any_hit && !IO_BUSY_OUT;

   always @(posedge CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         IO_CLAIM_OUT <= 1'b0;
         IO_WINDOW_SEL_OUT <= 1'b0;
         IO_WIDE_OUT <= 1'b0;
         MEM_CLAIM_OUT <= 5'h00;
         MEM_START_OUT <= 40'h0;
      end else begin
         IO_CLAIM_OUT <= take_io;
         if (take_io) begin
            IO_WINDOW_SEL_OUT <= sel;
            IO_WIDE_OUT <= win_wide[sel];
         end
         MEM_CLAIM_OUT <= HOST_MEM_REQ_IN ? mem_hit : 5'h00;
         MEM_START_OUT <= {mem_start_ff[4], mem_start_ff[3], mem_start_ff[2],
                           mem_start_ff[1], mem_start_ff[0]};
      end
   end

   pcw_cycle_timer #(
      .ISA_DIV(ISA_DIV)
   ) u_timer (
      .clk(CLK_IN),
      .rst_n(RST_N_IN),
      .start_in(take_io),
      .wide_in(win_wide[sel]),
      .long_in(win_long[sel]),
      .short_in(win_short[sel]),
      .busy_out(IO_BUSY_OUT),
      .done_out(IO_DONE_OUT)
   );
endmodule

// *** tb/pcw_top_asserts.sv ***
// concurrent checks on the socket window bank ports
`timescale 1ns/1ps
module pcw_top_chk #(parameter [7:0] ISA_DIV = 8'h03) (
   input wire CLK_IN,
   input wire RST_N_IN,
   input wire REG_RD_IN,
   input wire [7:0] REG_RDATA_OUT,
   input wire REG_RVALID_OUT,
   input wire [1:0] IO_WINDOW_ON_IN,
   input wire HOST_IO_REQ_IN,
   input wire HOST_MEM_REQ_IN,
   input wire [4:0] MEM_WINDOW_ON_IN,
   input wire [4:0] MEM_LIMIT_OK_IN,
   input wire IO_CLAIM_OUT,
   input wire IO_BUSY_OUT,
   input wire IO_DONE_OUT,
   input wire [4:0] MEM_CLAIM_OUT
);
   default clocking cb @(posedge CLK_IN); endclocking
   default disable iff (!RST_N_IN);
   // shortest is a 3-clock cycle, longest the 6-clock standard 8-bit one
   localparam int LO = 3 * ISA_DIV;
   localparam int HI = 6 * ISA_DIV;
   a_rd_answer: assert property (REG_RD_IN |=> REG_RVALID_OUT)
      else $error("read not answered");
   a_rdata_hold: assert property (!REG_RVALID_OUT |-> $stable(REG_RDATA_OUT))
      else $error("read data moved");
   a_off_quiet: assert property (HOST_IO_REQ_IN && IO_WINDOW_ON_IN == 2'h0 |=> !IO_CLAIM_OUT)
      else $error("disabled io claim");
   a_busy_refuse: assert property (HOST_IO_REQ_IN && IO_BUSY_OUT |=> !IO_CLAIM_OUT)
      else $error("claim while busy");
   a_claim_cause: assert property (IO_CLAIM_OUT |-> $past(HOST_IO_REQ_IN) && IO_BUSY_OUT)
      else $error("claim without request");
   a_cycle_len: assert property ($rose(IO_BUSY_OUT) |-> ##[LO:HI] IO_DONE_OUT)
      else $error("io cycle length");
   a_done_pulse: assert property (IO_DONE_OUT |-> !IO_BUSY_OUT ##1 !IO_DONE_OUT)
      else $error("done not a pulse");
   a_mem_gate: assert property (HOST_MEM_REQ_IN |=> (MEM_CLAIM_OUT &
      ~($past(MEM_WINDOW_ON_IN) & $past(MEM_LIMIT_OK_IN))) == 5'h00)
      else $error("memory claim not gated");
   a_mem_cause: assert property (MEM_CLAIM_OUT != 5'h00 |-> $past(HOST_MEM_REQ_IN))
      else $error("memory claim without request");
   c_io_claim: cover property (IO_CLAIM_OUT);
   c_io_done: cover property (IO_DONE_OUT);
   c_mem_claim: cover property (MEM_CLAIM_OUT != 5'h00);
endmodule
bind pcw_top pcw_top_chk #(.ISA_DIV(ISA_DIV)) u_chk (.CLK_IN, .RST_N_IN, .REG_RD_IN,
   .REG_RDATA_OUT, .REG_RVALID_OUT, .IO_WINDOW_ON_IN, .HOST_IO_REQ_IN, .HOST_MEM_REQ_IN,
   .MEM_WINDOW_ON_IN, .MEM_LIMIT_OK_IN, .IO_CLAIM_OUT, .IO_BUSY_OUT, .IO_DONE_OUT,
   .MEM_CLAIM_OUT);

// *** tb/pcw_card_model.sv ***
// card side: reports a 16-bit port on the active-low width line
`timescale 1ns/1ps
module pcw_card_model (
   input wire clk_in,
   input wire port16_in,
   output reg iois16_n_out
);
   initial iois16_n_out = 1'b1;
   // moves off the bus edge, as an unrelated card would
   always @(negedge clk_in) iois16_n_out <= !port16_in;
endmodule

// *** tb/tb_pcw_top.sv ***
// self-checking bench for the socket window bank
`timescale 1ns/1ps
module tb_pcw_top;
   reg CLK_IN = 1'b0, RST_N_IN = 1'b0, REG_WR_IN = 1'b0, REG_RD_IN = 1'b0;
   reg HOST_IO_REQ_IN = 1'b0, HOST_MEM_REQ_IN = 1'b0, p16 = 1'b0;
   reg [7:0] REG_ADDR_IN = 8'h00, REG_WDATA_IN = 8'h00;
   reg [1:0] IO_WINDOW_ON_IN = 2'h0;
   reg [4:0] MEM_WINDOW_ON_IN = 5'h00, MEM_LIMIT_OK_IN = 5'h00;
   reg [15:0] HOST_IO_ADDR_IN = 16'h0000;
   reg [23:0] HOST_MEM_ADDR_IN = 24'h000000;
   wire CARD_IOIS16_N_IN, REG_RVALID_OUT, IO_CLAIM_OUT, IO_WINDOW_SEL_OUT, IO_WIDE_OUT;
   wire IO_BUSY_OUT, IO_DONE_OUT;
   wire [7:0] REG_RDATA_OUT;
   wire [4:0] MEM_CLAIM_OUT;
   wire [39:0] MEM_START_OUT;
   integer fail_count = 0, check_count = 0, i;
   always #25 CLK_IN = !CLK_IN;
   // divider of one keeps timed cycles short; expected lengths scale with it
   pcw_top #(.ISA_DIV(8'h01)) DUT (.CLK_IN, .RST_N_IN, .REG_ADDR_IN, .REG_WDATA_IN,
      .REG_WR_IN, .REG_RD_IN, .REG_RDATA_OUT, .REG_RVALID_OUT, .IO_WINDOW_ON_IN,
      .MEM_WINDOW_ON_IN, .CARD_IOIS16_N_IN, .HOST_IO_REQ_IN, .HOST_IO_ADDR_IN,
      .HOST_MEM_REQ_IN, .HOST_MEM_ADDR_IN, .MEM_LIMIT_OK_IN, .IO_CLAIM_OUT,
      .IO_WINDOW_SEL_OUT, .IO_WIDE_OUT, .IO_BUSY_OUT, .IO_DONE_OUT, .MEM_CLAIM_OUT,
      .MEM_START_OUT);
   pcw_card_model card (.clk_in(CLK_IN), .port16_in(p16), .iois16_n_out(CARD_IOIS16_N_IN));
   function [7:0] off(input integer n);
      off = (n < 9) ? 8'h07 + n : 8'h10 + 8 * (n - 9);
   endfunction
   task chk(input [39:0] got, input [39:0] exp);
      begin
         check_count = check_count + 1;
         if (got !== exp) begin
            fail_count = fail_count + 1;
            $display("FAIL %0t got %h exp %h", $time, got, exp);
         end
      end
   endtask
   task wr(input [7:0] a, input [7:0] d);
      begin
         REG_ADDR_IN = a;
         REG_WDATA_IN = d;
         REG_WR_IN = 1'b1;
         @(negedge CLK_IN) REG_WR_IN = 1'b0;
         @(negedge CLK_IN);
      end
   endtask
   task rd(input [7:0] a, input [7:0] e);
      begin
         REG_ADDR_IN = a;
         REG_RD_IN = 1'b1;
         // valid stands only in the cycle after the strobe edge
         @(negedge CLK_IN) chk({REG_RVALID_OUT, REG_RDATA_OUT}, {1'b1, e});
         REG_RD_IN = 1'b0;
         @(negedge CLK_IN);
      end
   endtask
   // request held two edges: the second lands while busy and must be refused
   task io(input [15:0] a, input c, input w, input s, input integer n);
      integer k, cl;
      begin
         HOST_IO_ADDR_IN = a;
         HOST_IO_REQ_IN = 1'b1;
         k = 1;
         @(negedge CLK_IN) cl = (IO_CLAIM_OUT === 1'b1);
         while (IO_DONE_OUT !== 1'b1 && k < 20) begin
            @(negedge CLK_IN) k = k + 1;
            if (IO_CLAIM_OUT === 1'b1) cl = cl + 1;
            if (k == 2) HOST_IO_REQ_IN = 1'b0;
         end
         chk(cl, c);
         chk(k, n);
         if (c) chk({IO_WINDOW_SEL_OUT, IO_WIDE_OUT}, {s, w});
      end
   endtask
   task mem(input [7:0] a, input [4:0] on, input [4:0] ok, input [4:0] e);
      begin
         MEM_WINDOW_ON_IN = on;
         MEM_LIMIT_OK_IN = ok;
         HOST_MEM_ADDR_IN = {4'h0, a, 12'h000};
         HOST_MEM_REQ_IN = 1'b1;
         @(negedge CLK_IN) HOST_MEM_REQ_IN = 1'b0;
         chk(MEM_CLAIM_OUT, e);
         @(negedge CLK_IN);
      end
   endtask
   task t_zero;
      begin
         for (i = 0; i < 14; i = i + 1) rd(off(i), 8'h00);
         $display("zero test done");
      end
   endtask
   task t_regs;
      begin
         for (i = 0; i < 14; i = i + 1) wr(off(i), 8'h40 + i);
         wr(8'h11, 8'hff);
         for (i = 0; i < 14; i = i + 1) rd(off(i), 8'h40 + i);
         rd(8'h11, 8'h00);
         chk(MEM_START_OUT, 40'h4d4c4b4a49);
         mem(8'h4b, 5'h1e, 5'h1b, 5'h02);
         mem(8'h4d, 5'h1f, 5'h1f, 5'h1f);
         mem(8'h48, 5'h1f, 5'h1f, 5'h00);
         $display("register test done");
      end
   endtask
   task t_io;
      begin
         wr(8'h08, 8'h00);
         wr(8'h09, 8'h01);
         wr(8'h0a, 8'hff);
         wr(8'h0b, 8'h01);
         wr(8'h0c, 8'h00);
         wr(8'h0d, 8'h02);
         wr(8'h0e, 8'h10);
         wr(8'h0f, 8'h02);
         IO_WINDOW_ON_IN = 2'h3;
         io(16'h01ff, 1, 0, 0, 7);
         wr(8'h07, 8'h04);
         io(16'h0100, 1, 0, 0, 4);
         wr(8'h07, 8'h0c);
         io(16'h0100, 1, 0, 0, 4);
         wr(8'h07, 8'h01);
         io(16'h0100, 1, 1, 0, 4);
         wr(8'h07, 8'h09);
         io(16'h0100, 1, 1, 0, 5);
         p16 = 1'b1;
         wr(8'h07, 8'h05);
         io(16'h0100, 1, 1, 0, 4);
         wr(8'h07, 8'h02);
         io(16'h0100, 1, 1, 0, 4);
         p16 = 1'b0;
         wr(8'h07, 8'h03);
         repeat (3) @(negedge CLK_IN);
         io(16'h0100, 1, 0, 0, 7);
         wr(8'h07, 8'h90);
         io(16'h0200, 1, 1, 1, 5);
         io(16'h0210, 1, 1, 1, 5);
         io(16'h00ff, 0, 0, 0, 20);
         io(16'h0211, 0, 0, 0, 20);
         wr(8'h07, 8'h60);
         io(16'h0205, 1, 0, 1, 4);
         IO_WINDOW_ON_IN = 2'h0;
         io(16'h0100, 0, 0, 0, 20);
         IO_WINDOW_ON_IN = 2'h1;
         io(16'h0200, 0, 0, 0, 20);
         $display("io test done");
      end
   endtask
   task complete_run;
      begin
         $display("checks %0d mismatches %0d", check_count, fail_count);
         if (fail_count == 0 && check_count > 0) $display("ALL CHECKS OK");
         else $display("CHECKS NOT OK");
         $finish;
      end
   endtask
   initial begin
      repeat (20) @(negedge CLK_IN);
      RST_N_IN = 1'b1;
      t_zero;
      t_regs;
      RST_N_IN = 1'b0;
      repeat (2) @(negedge CLK_IN);
      RST_N_IN = 1'b1;
      t_zero;
      t_io;
      complete_run;
   end
   initial begin
      #500000;
      fail_count = fail_count + 1;
      complete_run;
   end
endmodule
